// [ssw_cpu_model.sv]
// Processor model: toggles its monitored line while running and out of reset.
// Assumes an active-low reset input and a gap well below the watchdog timeout.
`timescale 1ns/1ps
module ssw_cpu_model #(
  parameter int GAP = 7
) (
  input wire logic clk_i,
  input wire logic sys_reset_n_i,
  input wire logic run_i,
  output logic wdog_o
);
  int cnt = 0;
  initial wdog_o = 1'b0;
  // toggle within period
  // A stalled or held processor goes quiet, as a locked-up one would
  always @(posedge clk_i) begin
    if (!sys_reset_n_i || !run_i) begin
      cnt <= 0;
    end else if (cnt == GAP - 1) begin
      cnt <= 0;
      wdog_o <= #2 ~wdog_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [ssw_pkg.sv]
// Package for the supply supervisor with watchdog: timing constants and states.
// Assumes a single 40 MHz system clock; all inputs synchronous to it.
package ssw_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int NS_PER_S = 1000000000;
  localparam int CLK_NS = NS_PER_S / CLK_HZ;
  // Manual input must stay low longer than this (least time, round up)
  localparam int MAN_PULSE_NS = 25000;
  localparam int MAN_PULSE_CYC = (MAN_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Typical delay from qualified press to reset
  localparam int MAN_DELAY_NS = 12000;
  localparam int MAN_DELAY_CYC = (MAN_DELAY_NS + CLK_NS - 1) / CLK_NS;
  // Default reset timeout and watchdog timeout, in microseconds
  localparam int RST_TIMEOUT_US = 200;
  localparam int WDOG_TIMEOUT_US = 1600;
  localparam int NS_PER_US = 1000;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  typedef enum logic [1:0] {SSW_HOLD, SSW_RUN} ssw_state_t;
endpackage

// [ssw_supervisor.sv]
// Supply supervisor core: reset generation, manual reset, low-line and watchdog.
// Assumes supply comparator levels arrive as synchronous inputs from analog front end.
`timescale 1ns/1ps
// How it works
// - Reset asserted whenever supply is below reset threshold.
// - After supply recovers, reset releases only after full timeout period.
// - Reset output polarity is a build parameter, timing unchanged.
// - Manual input debounced; pull-up assumed so open input means no reset.
// - Manual low over 25 us asserts reset after 12 us more.
// - Reset holds while manual input low, then one full timeout.
// - Low-line output follows warning comparator with its hysteresis.
// - Any watchdog input edge clears the watchdog counter.
// - Watchdog counter reaching timeout activates reset.
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter bit RST_ACTIVE_HIGH = 1'b0,
  parameter int RST_TIMEOUT_CYC = RST_TIMEOUT_US * (NS_PER_US / CLK_NS),
  parameter int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_US * (NS_PER_US / CLK_NS)
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic SUPPLY_OK_I,
  input wire logic SUPPLY_WARN_OK_I,
  input wire logic MANUAL_RESET_N_I,
  input wire logic WATCHDOG_ACTIVITY_IN_I,
  output logic SYS_RESET_O,
  output logic LOW_LINE_WARN_N_O
);
  localparam logic [CNT_W-1:0] RST_TO = CNT_W'(RST_TIMEOUT_CYC);
  localparam logic [CNT_W-1:0] WDOG_TO = CNT_W'(WDOG_TIMEOUT_CYC);
  localparam logic [CNT_W-1:0] MAN_PULSE = CNT_W'(MAN_PULSE_CYC);
  localparam logic [CNT_W-1:0] MAN_DELAY = CNT_W'(MAN_DELAY_CYC);

  typedef struct packed {
    ssw_state_t state;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] man_cnt;
    logic [CNT_W-1:0] wdog_cnt;
    logic [CNT_W-1:0] man_dly;
    logic man_pend;
    logic man_held;
    logic act_prev;
    logic rst_act;
    logic warn_n;
  } ssw_regs_t;

  ssw_regs_t r_ff, nxt_r;

  // Saturating increment, used by every counter
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + CNT_ONE;
  endfunction

  logic act_edge;
  logic man_low;
  logic hold_cond;
  // Pull-up sits in the pad; an open pin reads high here
  assign man_low = ~MANUAL_RESET_N_I;
  assign act_edge = WATCHDOG_ACTIVITY_IN_I ^ r_ff.act_prev;
  // Hold while supply low or a fired press is still down
  assign hold_cond = ~SUPPLY_OK_I | r_ff.man_held;

  // Next-state logic for the whole supervisor
  always_comb begin
    nxt_r = r_ff;
    nxt_r.act_prev = WATCHDOG_ACTIVITY_IN_I;
    // comparator hysteresis lives in front end
    nxt_r.warn_n = SUPPLY_WARN_OK_I;
    // debounce by low-time count
    // Any high sample restarts the count, so bounces never add up
    if (!man_low) begin
      nxt_r.man_cnt = CNT_ZERO;
    end else begin
      nxt_r.man_cnt = sat_inc(r_ff.man_cnt);
      if (r_ff.man_cnt == MAN_PULSE) begin
        nxt_r.man_pend = 1'b1;
      end
    end
    // delay then hold while low
    // Delay runs on after an early release, so a qualified press always lands
    nxt_r.man_held = r_ff.man_held & man_low;
    if (r_ff.man_pend) begin
      if (r_ff.man_dly == MAN_DELAY - CNT_ONE) begin
        nxt_r.man_pend = 1'b0;
        nxt_r.man_dly = CNT_ZERO;
        nxt_r.man_held = 1'b1;
      end else begin
        nxt_r.man_dly = sat_inc(r_ff.man_dly);
      end
    end
    unique case (r_ff.state)
      SSW_HOLD: begin
        nxt_r.rst_act = 1'b1;
        nxt_r.wdog_cnt = CNT_ZERO;
        // restart timer on any hold cause
        if (hold_cond) begin
          nxt_r.rst_cnt = CNT_ZERO;
        end else if (r_ff.rst_cnt >= RST_TO - CNT_ONE) begin
          nxt_r.state = SSW_RUN;
          nxt_r.rst_act = 1'b0;
          nxt_r.rst_cnt = CNT_ZERO;
        end else begin
          nxt_r.rst_cnt = sat_inc(r_ff.rst_cnt);
        end
      end
      SSW_RUN: begin
        nxt_r.rst_act = 1'b0;
        if (hold_cond || (!act_edge && r_ff.wdog_cnt >= WDOG_TO - CNT_ONE)) begin
          nxt_r.state = SSW_HOLD;
          nxt_r.rst_act = 1'b1;
          nxt_r.rst_cnt = CNT_ZERO;
          nxt_r.wdog_cnt = CNT_ZERO;
        end else if (act_edge) begin
          nxt_r.wdog_cnt = CNT_ZERO;
        end else begin
          nxt_r.wdog_cnt = sat_inc(r_ff.wdog_cnt);
        end
      end
      default: begin
        nxt_r.state = SSW_HOLD;
      end
    endcase
  end

  // Power-on reset puts the processor in reset
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r_ff <= '{state: SSW_HOLD, rst_cnt: CNT_ZERO, man_cnt: CNT_ZERO,
                wdog_cnt: CNT_ZERO, man_dly: CNT_ZERO, man_pend: 1'b0,
                man_held: 1'b0, act_prev: 1'b0, rst_act: 1'b1, warn_n: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign SYS_RESET_O = RST_ACTIVE_HIGH ? r_ff.rst_act : ~r_ff.rst_act;
  assign LOW_LINE_WARN_N_O = r_ff.warn_n;

  property p_supply_low;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I) !SUPPLY_OK_I |=> r_ff.rst_act;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("reset missing on low supply");

  property p_release_wait;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $fell(r_ff.rst_act) |-> $past(r_ff.rst_cnt) == RST_TO - CNT_ONE;
  endproperty
  a_release_wait: assert property (p_release_wait) else $error("release before timeout");

  // Pin level tied to the state, not to the internal flag
  property p_polarity;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      SYS_RESET_O == ((r_ff.state == SSW_RUN) ? !RST_ACTIVE_HIGH : RST_ACTIVE_HIGH);
  endproperty
  a_polarity: assert property (p_polarity) else $error("reset polarity wrong");

  // A press only qualifies after the full low time
  property p_short_press;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(r_ff.man_pend) |-> $past(man_low) && $past(r_ff.man_cnt) == MAN_PULSE;
  endproperty
  a_short_press: assert property (p_short_press) else $error("glitch qualified");

  property p_press_qual;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      man_low && r_ff.man_cnt == MAN_PULSE |=> r_ff.man_pend || r_ff.man_held;
  endproperty
  a_press_qual: assert property (p_press_qual) else $error("press not qualified");

  property p_press_hold;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      r_ff.man_held |=> r_ff.rst_act;
  endproperty
  a_press_hold: assert property (p_press_hold) else $error("reset dropped while pressed");

  // Qualified press whose delay has just run out
  sequence s_delay_done;
    r_ff.man_pend && r_ff.man_dly == MAN_DELAY - CNT_ONE;
  endsequence

  // Hold request raised, then reset taken one cycle on
  sequence s_reset_taken;
    r_ff.man_held ##1 r_ff.rst_act;
  endsequence

  property p_press_fire;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      s_delay_done |=> s_reset_taken;
  endproperty
  a_press_fire: assert property (p_press_fire) else $error("press delay lost");

  // Release timer only starts once every hold cause is gone
  property p_hold_restart;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      hold_cond |=> r_ff.rst_act && r_ff.rst_cnt == CNT_ZERO;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("timer ran during hold");

  property p_low_line;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      1'b1 |=> LOW_LINE_WARN_N_O == $past(SUPPLY_WARN_OK_I);
  endproperty
  a_low_line: assert property (p_low_line) else $error("low-line mismatch");

  property p_act_clear;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      act_edge && r_ff.state == SSW_RUN && !hold_cond |=> r_ff.wdog_cnt == CNT_ZERO;
  endproperty
  a_act_clear: assert property (p_act_clear) else $error("edge did not clear");

  property p_wdog_fire;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      r_ff.state == SSW_RUN && !act_edge && r_ff.wdog_cnt == WDOG_TO - CNT_ONE
      |=> r_ff.rst_act;
  endproperty
  a_wdog_fire: assert property (p_wdog_fire) else $error("watchdog did not fire");

  property p_wdog_held;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      r_ff.rst_act |=> r_ff.wdog_cnt == CNT_ZERO;
  endproperty
  a_wdog_held: assert property (p_wdog_held) else $error("watchdog ran in reset");

  // Counting starts from zero on the first running cycle
  property p_wdog_restart;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $fell(r_ff.rst_act) |-> r_ff.state == SSW_RUN && r_ff.wdog_cnt == CNT_ZERO;
  endproperty
  a_wdog_restart: assert property (p_wdog_restart) else $error("watchdog not restarted");
endmodule

// [supply_supervisor_watchdog_bench.sv]
// Bench for the supervisor: supply, manual, low-line and watchdog scenarios.
// Assumes short timeouts; expected release windows allow three cycles of latency.
`timescale 1ns/1ps
module supply_supervisor_watchdog_bench;
  import ssw_pkg::*;
  localparam int TR = 20;
  localparam int TW = 50;
  logic clk = 1'b0, rst_n = 1'b0, sup = 1'b1, warn = 1'b1, man_n = 1'b1, run = 1'b1;
  logic wd, rst_o, rst_h, low_n;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [31:0] x = 32'h4403;
  always #12.5 clk = ~clk;
  ssw_supervisor #(.RST_TIMEOUT_CYC(TR), .WDOG_TIMEOUT_CYC(TW)) DUT (.CLK_SYS_I(clk),
    .RST_N_I(rst_n), .SUPPLY_OK_I(sup), .SUPPLY_WARN_OK_I(warn),
    .MANUAL_RESET_N_I(man_n), .WATCHDOG_ACTIVITY_IN_I(wd), .SYS_RESET_O(rst_o),
    .LOW_LINE_WARN_N_O(low_n));
  // Active-high variant sees the same pins; only the reset level differs
  ssw_supervisor #(.RST_ACTIVE_HIGH(1'b1), .RST_TIMEOUT_CYC(TR),
    .WDOG_TIMEOUT_CYC(TW)) DUT_H (.CLK_SYS_I(clk),
    .RST_N_I(rst_n), .SUPPLY_OK_I(sup), .SUPPLY_WARN_OK_I(warn),
    .MANUAL_RESET_N_I(man_n), .WATCHDOG_ACTIVITY_IN_I(wd), .SYS_RESET_O(rst_h),
    .LOW_LINE_WARN_N_O());
  ssw_cpu_model CPU (.clk_i(clk), .sys_reset_n_i(rst_o), .run_i(run), .wdog_o(wd));
  // Xorshift source for the random warning levels
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Expected reset state, active low output by default
  task chk(input bit e, input string n);
    cmp_count++;
    if (rst_o !== !e) begin
      error_cnt++;
      $display("BAD %s exp %b seen %b", n, !e, rst_o);
    end
    cmp_count++;
    if (rst_h !== e) begin
      error_cnt++;
      $display("BAD %s high variant exp %b seen %b", n, e, rst_h);
    end
  endtask
  task conclude;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far above the whole sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // Releases are checked in a window: TR-3 still held, TR+3 released
  task release_win(input string n);
    step(TR - 3);
    chk(1, n);
    step(6);
    chk(0, n);
  endtask
  initial begin
    step(4);
    rst_n = 1'b1;
    release_win("por");
    sup = 1'b0;
    step(2);
    chk(1, "brownout");
    sup = 1'b1;
    release_win("supply");
    // Random warning levels, registered copy one cycle on
    repeat (8) begin
      x = xs(x);
      warn = x[0];
      step(2);
      cmp_count++;
      if (low_n !== warn) begin
        error_cnt++;
        $display("BAD lowline exp %b seen %b", warn, low_n);
      end
    end
    man_n = 1'b0;
    step(MAN_PULSE_CYC - 10);
    man_n = 1'b1;
    step(2);
    chk(0, "short press");
    man_n = 1'b0;
    step(MAN_PULSE_CYC + MAN_DELAY_CYC - 2);
    chk(0, "press early");
    step(5);
    chk(1, "press");
    step(200);
    chk(1, "held");
    man_n = 1'b1;
    release_win("press end");
    step(TW + 20);
    chk(0, "fed");
    run = 1'b0;
    step(TW - 10);
    chk(0, "starving");
    step(14);
    chk(1, "starved");
    run = 1'b1;
    step(TR + 6);
    chk(0, "wdog end");
    step(TW + 20);
    chk(0, "refed");
    // Press past the qualifying time but released inside the delay
    man_n = 1'b0;
    step(MAN_PULSE_CYC + 20);
    man_n = 1'b1;
    step(MAN_DELAY_CYC - 40);
    chk(0, "late fire early");
    step(23);
    chk(1, "late fire");
    release_win("late fire end");
    conclude();
  end
endmodule
